// *** logic/pps_pkg.sv ***
// Purpose: shared constants and types of the passive parallel slave port
// Assumes: AHB-Lite register access, 32-bit data, one register per word
// Notes: printed offsets are register indices; byte address is four times the index
package pps_pkg;

    // ==========================================================
    // register indices and byte addresses
    localparam logic [31:0] IDX_CONFIG = 32'h4000101C;
    localparam logic [31:0] IDX_RD_STAT = 32'h40001096;
    localparam logic [31:0] IDX_WR_CAPT = 32'h40001097;
    localparam logic [31:0] IDX_RD_DATA = 32'h400010C8;
    localparam logic [31:0] IDX_PA_OUT = 32'h40001100;
    localparam logic [31:0] IDX_EVT_STAT = 32'h40001101;
    localparam logic [31:0] IDX_EVT_MASK = 32'h40001102;
    localparam int ADDR_LSB = 2;
    localparam int DEC_W = 14;

    // ==========================================================
    // configuration register fields and interrupt source bit positions
    localparam int CFG_EN = 0;
    localparam int CFG_IE_CMD = 1;
    localparam int CFG_IE_WR = 2;
    localparam int CFG_IE_RD = 3;
    localparam int CFG_F_CMD = 5;
    localparam int CFG_F_WR = 6;
    localparam int CFG_F_RD = 7;
    localparam int STAT_IRQ_BIT = 7;
    localparam int PA_IRQ_BIT = 3;

    // event status / mask bits
    localparam int EVT_RD = 0;
    localparam int EVT_WR_DATA = 1;
    localparam int EVT_WR_CMD = 2;
    localparam int EVT_W = 3;

    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // ==========================================================
    // types
    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic cmd_sel;
        logic [7:0] data;
    } pps_pins_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WAIT = 2'b01,
        BUS_DONE = 2'b10
    } pps_bus_t;

    typedef struct packed {
        logic en;
        logic ie_rd;
        logic ie_wr;
        logic ie_cmd;
        logic f_rd;
        logic f_wr;
        logic f_cmd;
    } pps_cfg_t;

endpackage : pps_pkg

// *** logic/pps_port.sv ***
// Purpose: passive 8-bit parallel slave port with AHB-Lite register access
// Assumes: host pins are asynchronous to mclk and are held for several mclk cycles
// Notes: host strobes pass two flip-flops; captures happen on strobe release
// Function
// - while chip select is high the port does nothing and leaves the data lines undriven.
// - chip select low with both strobes high moves nothing and leaves the lines undriven.
// - the data bus is an input during writes and is driven only during reads.
// - a write with the select line high captures the byte as a command, read strobe ignored.
// - a write with the select line low captures the byte as data.
// - a read with the select line high drives the preset status byte.
// - a read with the select line low drives the preset read-data byte.
// - the host interrupt line is the OR of status bit 7 and port A output bit 3, low means request.
// - capture, status and read-data storage replace the port B registers while enabled.
// - configuration bit 0 enables the port and resets to 0.
// - configuration bit 7 sets when a host read completes and clears by writing 1.
// - configuration bit 6 sets when a host write completes and clears by writing 1.
// - configuration bit 5 reads 1 while the latest captured write was a command.
// - configuration bits 3, 2 and 1 enable read, data-write and command-write interrupts.
// - software presets status bit 7 high so the request line idles high.
// - after the read flag, software may preset the next byte for the host.
`timescale 1ns/100ps
module pps_port (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic host_chip_select_n,
    input wire logic host_write_strobe_n,
    input wire logic host_read_strobe_n,
    input wire logic host_cmd_data_select,
    input wire logic [7:0] host_data_bus_in,
    output logic [7:0] host_data_bus_out,
    output logic host_data_bus_oe,
    output logic host_irq_n,
    output logic cpu_irq
);

    // ==========================================================
    // state
    typedef struct packed {
        pps_pkg::pps_pins_t sync1;
        pps_pkg::pps_pins_t sync2;
        pps_pkg::pps_pins_t prev;
        pps_pkg::pps_cfg_t cfg;
        logic [7:0] rd_stat;
        logic [7:0] rd_data;
        logic [7:0] wr_capt;
        logic [7:0] pa_out;
        logic [pps_pkg::EVT_W-1:0] evt_stat;
        logic [pps_pkg::EVT_W-1:0] evt_mask;
        pps_pkg::pps_bus_t bus;
        logic ph_write;
        logic [pps_pkg::DEC_W-1:0] ph_addr;
        logic hready;
        logic [31:0] hrdata;
        logic [7:0] dout;
        logic doe;
        logic irq_n;
        logic irq;
    } pps_state_t;

    localparam pps_state_t STATE_RESET = '{
        sync1: '1,
        sync2: '1,
        prev: '1,
        cfg: '0,
        rd_stat: pps_pkg::BYTE_RESET,
        rd_data: pps_pkg::BYTE_RESET,
        wr_capt: pps_pkg::BYTE_RESET,
        pa_out: pps_pkg::BYTE_RESET,
        evt_stat: '0,
        evt_mask: '0,
        bus: pps_pkg::BUS_IDLE,
        ph_write: 1'b0,
        ph_addr: '0,
        hready: 1'b1,
        hrdata: 32'h0000_0000,
        dout: pps_pkg::BYTE_RESET,
        doe: 1'b0,
        irq_n: 1'b0,
        irq: 1'b0
    };

    pps_state_t s_r;
    pps_state_t s_nxt;

    // ==========================================================
    // helpers
    // word address bits compared against an index; four times the index is the byte address
    function automatic logic [pps_pkg::DEC_W-1:0] word_of(input logic [31:0] idx);
        logic [31:0] byte_addr;
        byte_addr = {idx[29:0], 2'b00};
        word_of = byte_addr[pps_pkg::ADDR_LSB +: pps_pkg::DEC_W];
    endfunction : word_of

    function automatic pps_pkg::pps_cfg_t cfg_of(input logic [7:0] b, input pps_pkg::pps_cfg_t old);
        pps_pkg::pps_cfg_t c;
        c = old;
        c.en = b[pps_pkg::CFG_EN];
        c.ie_cmd = b[pps_pkg::CFG_IE_CMD];
        c.ie_wr = b[pps_pkg::CFG_IE_WR];
        c.ie_rd = b[pps_pkg::CFG_IE_RD];
        cfg_of = c;
    endfunction : cfg_of

    function automatic logic [7:0] cfg_byte(input pps_pkg::pps_cfg_t c);
        logic [7:0] b;
        b = 8'h00;
        b[pps_pkg::CFG_EN] = c.en;
        b[pps_pkg::CFG_IE_CMD] = c.ie_cmd;
        b[pps_pkg::CFG_IE_WR] = c.ie_wr;
        b[pps_pkg::CFG_IE_RD] = c.ie_rd;
        b[pps_pkg::CFG_F_CMD] = c.f_cmd;
        b[pps_pkg::CFG_F_WR] = c.f_wr;
        b[pps_pkg::CFG_F_RD] = c.f_rd;
        cfg_byte = b;
    endfunction : cfg_byte

    // ==========================================================
    // next state
    always_comb begin
        logic sel;
        logic wr_end;
        logic rd_end;
        logic rd_active;
        logic sw_wr;
        logic [7:0] wb;
        logic [pps_pkg::EVT_W-1:0] evt_set;
        logic [pps_pkg::EVT_W-1:0] evt_clr;
        logic cfg_rd_clr;
        logic cfg_wr_clr;
        sel = 1'b0;
        wr_end = 1'b0;
        rd_end = 1'b0;
        rd_active = 1'b0;
        sw_wr = 1'b0;
        wb = hwdata[7:0];
        evt_set = '0;
        evt_clr = '0;
        cfg_rd_clr = 1'b0;
        cfg_wr_clr = 1'b0;
        s_nxt = s_r;

        // host pins: first stage feeds only the second
        s_nxt.sync1 = '{cs_n: host_chip_select_n, wr_n: host_write_strobe_n, rd_n: host_read_strobe_n,
                        cmd_sel: host_cmd_data_select, data: host_data_bus_in};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev = s_r.sync2;

        // strobe release ends a transfer; prev still holds the settled bus and select line
        sel = s_r.cfg.en && !s_r.prev.cs_n;
        wr_end = sel && !s_r.prev.wr_n && s_r.sync2.wr_n;
        rd_end = sel && s_r.prev.wr_n && !s_r.prev.rd_n && s_r.sync2.rd_n;
        rd_active = s_r.cfg.en && !s_r.sync2.cs_n && s_r.sync2.wr_n && !s_r.sync2.rd_n;

        // ==========================================================
        // host side
        if (wr_end) begin
            s_nxt.wr_capt = s_r.prev.data;
            s_nxt.cfg.f_cmd = s_r.prev.cmd_sel;
            evt_set[pps_pkg::EVT_WR_CMD] = s_r.prev.cmd_sel;
            evt_set[pps_pkg::EVT_WR_DATA] = !s_r.prev.cmd_sel;
        end
        evt_set[pps_pkg::EVT_RD] = rd_end;

        s_nxt.doe = rd_active;
        if (rd_active) begin
            s_nxt.dout = s_r.sync2.cmd_sel ? s_r.rd_stat : s_r.rd_data;
        end

        // ==========================================================
        // bus slave: one wait cycle so read data leaves a flip-flop
        s_nxt.hready = 1'b1;
        unique case (s_r.bus)
            pps_pkg::BUS_IDLE: begin
                if (hsel && hready && htrans == pps_pkg::HTRANS_NONSEQ) begin
                    s_nxt.bus = pps_pkg::BUS_WAIT;
                    s_nxt.ph_write = hwrite;
                    s_nxt.ph_addr = haddr[pps_pkg::ADDR_LSB +: pps_pkg::DEC_W];
                    s_nxt.hready = 1'b0;
                end
            end
            pps_pkg::BUS_WAIT: begin
                s_nxt.bus = pps_pkg::BUS_DONE;
                sw_wr = s_r.ph_write;
                s_nxt.hrdata = 32'h0000_0000;
                if (!s_r.ph_write) begin
                    if (s_r.ph_addr == word_of(pps_pkg::IDX_CONFIG)) begin
                        s_nxt.hrdata[7:0] = cfg_byte(s_r.cfg);
                    end else if (s_r.ph_addr == word_of(pps_pkg::IDX_RD_STAT)) begin
                        s_nxt.hrdata[7:0] = s_r.rd_stat;
                    end else if (s_r.ph_addr == word_of(pps_pkg::IDX_WR_CAPT)) begin
                        s_nxt.hrdata[7:0] = s_r.wr_capt;
                    end else if (s_r.ph_addr == word_of(pps_pkg::IDX_RD_DATA)) begin
                        s_nxt.hrdata[7:0] = s_r.rd_data;
                    end else if (s_r.ph_addr == word_of(pps_pkg::IDX_PA_OUT)) begin
                        s_nxt.hrdata[7:0] = s_r.pa_out;
                    end else if (s_r.ph_addr == word_of(pps_pkg::IDX_EVT_STAT)) begin
                        s_nxt.hrdata[pps_pkg::EVT_W-1:0] = s_r.evt_stat;
                    end else if (s_r.ph_addr == word_of(pps_pkg::IDX_EVT_MASK)) begin
                        s_nxt.hrdata[pps_pkg::EVT_W-1:0] = s_r.evt_mask;
                    end
                end
            end
            pps_pkg::BUS_DONE: begin
                // back to back: a new address phase may sit beside this data phase
                s_nxt.bus = pps_pkg::BUS_IDLE;
                if (hsel && hready && htrans == pps_pkg::HTRANS_NONSEQ) begin
                    s_nxt.bus = pps_pkg::BUS_WAIT;
                    s_nxt.ph_write = hwrite;
                    s_nxt.ph_addr = haddr[pps_pkg::ADDR_LSB +: pps_pkg::DEC_W];
                    s_nxt.hready = 1'b0;
                end
            end
            default: begin
                s_nxt.bus = pps_pkg::BUS_IDLE;
            end
        endcase

        // ==========================================================
        // software writes; unmapped addresses read zero and ignore writes
        if (sw_wr) begin
            if (s_r.ph_addr == word_of(pps_pkg::IDX_CONFIG)) begin
                s_nxt.cfg = cfg_of(wb, s_r.cfg);
                cfg_rd_clr = wb[pps_pkg::CFG_F_RD];
                cfg_wr_clr = wb[pps_pkg::CFG_F_WR];
            end else if (s_r.ph_addr == word_of(pps_pkg::IDX_RD_STAT)) begin
                s_nxt.rd_stat = wb;
            end else if (s_r.ph_addr == word_of(pps_pkg::IDX_RD_DATA)) begin
                s_nxt.rd_data = wb;
            end else if (s_r.ph_addr == word_of(pps_pkg::IDX_PA_OUT)) begin
                s_nxt.pa_out = wb;
            end else if (s_r.ph_addr == word_of(pps_pkg::IDX_EVT_STAT)) begin
                evt_clr = wb[pps_pkg::EVT_W-1:0];
            end else if (s_r.ph_addr == word_of(pps_pkg::IDX_EVT_MASK)) begin
                s_nxt.evt_mask = wb[pps_pkg::EVT_W-1:0];
            end
        end

        // a host event in the clearing cycle survives the clear
        s_nxt.cfg.f_rd = rd_end || (s_r.cfg.f_rd && !cfg_rd_clr);
        s_nxt.cfg.f_wr = wr_end || (s_r.cfg.f_wr && !cfg_wr_clr);
        s_nxt.evt_stat = evt_set | (s_r.evt_stat & ~evt_clr);

        // ==========================================================
        // interrupt lines, registered from current register contents
        s_nxt.irq_n = s_r.rd_stat[pps_pkg::STAT_IRQ_BIT] | s_r.pa_out[pps_pkg::PA_IRQ_BIT];
        s_nxt.irq = (s_r.cfg.f_rd && s_r.cfg.ie_rd)
                  || (s_r.cfg.f_wr && s_r.cfg.ie_wr && !s_r.cfg.f_cmd)
                  || (s_r.cfg.f_wr && s_r.cfg.ie_cmd && s_r.cfg.f_cmd)
                  || (|(s_r.evt_stat & s_r.evt_mask));
    end

    // ==========================================================
    // registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r <= STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign hreadyout = s_r.hready;
    assign hrdata = s_r.hrdata;
    assign hresp = pps_pkg::HRESP_OKAY;
    assign host_data_bus_out = s_r.dout;
    assign host_data_bus_oe = s_r.doe;
    assign host_irq_n = s_r.irq_n;
    assign cpu_irq = s_r.irq;

    // unused by design: only whole-word transfers are expected
    logic unused_ok;
    assign unused_ok = ^{hsize, hwdata[31:8], haddr[31:16], haddr[1:0]};

endmodule : pps_port

// *** sim/pps_port_asserts.sv ***
// Purpose: port-level checks of the parallel slave port
// Assumes: one AHB-Lite slave, hready tied to hreadyout
// Notes: shadows enable, status, read data and port A bit 3
`timescale 1ns/100ps
module pps_port_asserts (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic host_chip_select_n,
    input wire logic host_write_strobe_n,
    input wire logic host_read_strobe_n,
    input wire logic host_cmd_data_select,
    input wire logic [7:0] host_data_bus_out,
    input wire logic host_data_bus_oe,
    input wire logic host_irq_n,
    input wire logic cpu_irq
);
    // ======
    // register shadow
    localparam logic [31:0] A_CF = pps_pkg::IDX_CONFIG << pps_pkg::ADDR_LSB;
    localparam logic [31:0] A_ST = pps_pkg::IDX_RD_STAT << pps_pkg::ADDR_LSB;
    localparam logic [31:0] A_RD = pps_pkg::IDX_RD_DATA << pps_pkg::ADDR_LSB;
    localparam logic [31:0] A_PA = pps_pkg::IDX_PA_OUT << pps_pkg::ADDR_LSB;
    logic take;
    logic done;
    logic pend_r, wr_r, en_r, pa3_r;
    logic [15:0] adr_r;
    logic [7:0] st_r, rd_r;
    logic irq_m;
    logic sel_rd;
    assign take = hsel && hready && htrans == pps_pkg::HTRANS_NONSEQ;
    assign done = pend_r && hreadyout && wr_r;
    assign irq_m = st_r[7] | pa3_r;
    assign sel_rd = !host_chip_select_n && host_write_strobe_n && !host_read_strobe_n && en_r;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
            wr_r <= 1'b0;
            adr_r <= 16'h0000;
            {en_r, pa3_r, st_r, rd_r} <= 18'h00000;
        end else begin
            pend_r <= take | (pend_r & !hreadyout);
            if (take) begin
                wr_r <= hwrite;
                adr_r <= haddr[15:0];
            end
            if (done && adr_r == A_CF[15:0]) en_r <= hwdata[0];
            if (done && adr_r == A_ST[15:0]) st_r <= hwdata[7:0];
            if (done && adr_r == A_RD[15:0]) rd_r <= hwdata[7:0];
            if (done && adr_r == A_PA[15:0]) pa3_r <= hwdata[3];
        end
    end
    // ======
    // properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    hresp_okay_a: assert property (hresp == pps_pkg::HRESP_OKAY) else $error("hresp not okay");
    wait_state_a: assert property (take |=> !hreadyout ##1 hreadyout) else $error("wait state count");
    rdata_upper_a: assert property (pend_r && hreadyout && !wr_r |-> hrdata[31:8] == 24'h0)
        else $error("hrdata upper bits");
    cs_idle_a: assert property (host_chip_select_n [*5] |=> !host_data_bus_oe)
        else $error("bus driven while unselected");
    no_strobe_a: assert property ((!host_chip_select_n && host_write_strobe_n && host_read_strobe_n) [*5]
        |=> !host_data_bus_oe) else $error("bus driven with no strobe");
    wr_input_a: assert property (!host_write_strobe_n [*5] |=> !host_data_bus_oe)
        else $error("bus driven during write");
    rd_stat_a: assert property ((sel_rd && host_cmd_data_select && $stable(st_r)) [*5]
        |=> host_data_bus_oe && host_data_bus_out == st_r) else $error("status byte not driven");
    rd_data_a: assert property ((sel_rd && !host_cmd_data_select && $stable(rd_r)) [*5]
        |=> host_data_bus_oe && host_data_bus_out == rd_r) else $error("data byte not driven");
    host_irq_a: assert property ($past(irq_m, 2) == irq_m && $past(irq_m) == irq_m
        |-> host_irq_n == irq_m) else $error("host irq level");
    cover property (take && hwrite);
    cover property (cpu_irq);
    cover property (sel_rd && host_cmd_data_select);
    cover property (!host_irq_n ##1 host_irq_n);
endmodule : pps_port_asserts
bind pps_port pps_port_asserts pps_port_asserts_inst (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .hrdata, .hresp, .host_chip_select_n, .host_write_strobe_n,
    .host_read_strobe_n, .host_cmd_data_select, .host_data_bus_out, .host_data_bus_oe, .host_irq_n, .cpu_irq);

// *** sim/pps_host_model.sv ***
// Purpose: external host that writes and reads the parallel port
// Assumes: tasks are entered just after a rising mclk edge
// Notes: released data lines float to the pull-up level
`timescale 1ns/100ps
module pps_host_model (
    input wire logic mclk,
    input wire logic [7:0] bus_out,
    input wire logic bus_oe,
    output pps_pkg::pps_pins_t pins
);
    pps_pkg::pps_pins_t p = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
    logic drv = 1'b0;
    logic [7:0] lvl;
    assign lvl = bus_oe ? bus_out : (drv ? p.data : 8'hFF);
    assign pins = {p.cs_n, p.wr_n, p.rd_n, p.cmd_sel, lvl};
    task automatic host_write(input logic s, input logic [7:0] b);
        p.cs_n <= 1'b0;
        p.cmd_sel <= s;
        p.data <= b;
        drv <= 1'b1;
        repeat (4) @(posedge mclk);
        p.wr_n <= 1'b0;
        repeat (6) @(posedge mclk);
        p.wr_n <= 1'b1;
        // select kept low past the strobe so the idle-select window is seen
        repeat (5) @(posedge mclk);
        p.cs_n <= 1'b1;
        drv <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask : host_write
    task automatic host_read(input logic s, output logic [7:0] q);
        p.cs_n <= 1'b0;
        p.cmd_sel <= s;
        repeat (4) @(posedge mclk);
        p.rd_n <= 1'b0;
        repeat (8) @(posedge mclk);
        q = lvl;
        p.rd_n <= 1'b1;
        repeat (5) @(posedge mclk);
        p.cs_n <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask : host_read
endmodule : pps_host_model

// *** sim/passive_parallel_slave_port_tb.sv ***
// Purpose: self-checking bench of the parallel slave port
// Assumes: hready tied to hreadyout, word transfers only
// Notes: random bytes from a fixed xorshift seed
`timescale 1ns/100ps
module passive_parallel_slave_port_tb;
    localparam logic [31:0] A_CF = pps_pkg::IDX_CONFIG << pps_pkg::ADDR_LSB;
    localparam logic [31:0] A_ST = pps_pkg::IDX_RD_STAT << pps_pkg::ADDR_LSB;
    localparam logic [31:0] A_WC = pps_pkg::IDX_WR_CAPT << pps_pkg::ADDR_LSB;
    localparam logic [31:0] A_RD = pps_pkg::IDX_RD_DATA << pps_pkg::ADDR_LSB;
    localparam logic [31:0] A_PA = pps_pkg::IDX_PA_OUT << pps_pkg::ADDR_LSB;
    localparam logic [31:0] A_ES = pps_pkg::IDX_EVT_STAT << pps_pkg::ADDR_LSB;
    localparam logic [31:0] A_EM = pps_pkg::IDX_EVT_MASK << pps_pkg::ADDR_LSB;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, host_data_bus_oe, host_irq_n, cpu_irq;
    logic [7:0] host_data_bus_out;
    pps_pkg::pps_pins_t pins;
    logic [31:0] seed = 32'h0000725F;
    int err_count = 0;
    int n_checks = 0;
    always #10 mclk = ~mclk;
    pps_port pps_port_inst (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .host_chip_select_n(pins.cs_n),
        .host_write_strobe_n(pins.wr_n), .host_read_strobe_n(pins.rd_n), .host_cmd_data_select(pins.cmd_sel),
        .host_data_bus_in(pins.data), .host_data_bus_out, .host_data_bus_oe, .host_irq_n, .cpu_irq);
    pps_host_model pps_host_model_inst (.mclk, .bus_out(host_data_bus_out), .bus_oe(host_data_bus_oe), .pins);
    // ======
    // helpers
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function logic [31:0] cfg_exp(logic [3:0] ie_en, logic f_rd, logic f_wr, logic f_cmd);
        return {24'h0, f_rd, f_wr, f_cmd, 1'b0, ie_en};
    endfunction : cfg_exp
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= pps_pkg::HTRANS_NONSEQ;
        // ready is looked at mid-cycle, where it stands settled for the next rising edge
        do @(negedge mclk); while (hreadyout !== 1'b1);
        @(posedge mclk);
        htrans <= 2'h0;
        hwdata <= d;
        do @(negedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
        @(posedge mclk);
    endtask : xfer
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask : wr
    task rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0, q);
        chk(nm, q, exp);
    endtask : rdc
    task complete_run();
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    // ======
    // scenarios
    initial begin : main
        logic [31:0] r, st, dt;
        logic [7:0] q;
        logic s;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk("irq_n_rst", {31'h0, host_irq_n}, 32'h0);
        rdc("cfg_rst", A_CF, 32'h0);
        rdc("stat_rst", A_ST, 32'h0);
        rdc("capt_rst", A_WC, 32'h0);
        rdc("rdat_rst", A_RD, 32'h0);
        rdc("unmapped", 32'h00004500, 32'h0);
        pps_host_model_inst.host_write(1'b1, 8'h5A);
        rdc("capt_off", A_WC, 32'h0);
        wr(A_ST, 32'h80);
        for (int i = 0; i < 8; i++) begin
            r = xs();
            s = (i < 2) ? i[0] : r[8];
            wr(A_CF, {28'h0, r[11:9], 1'b1});
            pps_host_model_inst.host_write(s, r[7:0]);
            rdc("capt", A_WC, {24'h0, r[7:0]});
            rdc("cfg_wr", A_CF, cfg_exp({r[11:9], 1'b1}, 1'b0, 1'b1, s));
            chk("cpu_irq_wr", {31'h0, cpu_irq}, {31'h0, s ? r[9] : r[10]});
            wr(A_CF, {24'h0, 4'h4, r[11:9], 1'b1});
            rdc("cfg_wclr", A_CF, cfg_exp({r[11:9], 1'b1}, 1'b0, 1'b0, s));
            chk("cpu_irq_clr", {31'h0, cpu_irq}, 32'h0);
        end
        wr(A_CF, 32'h09);
        for (int i = 0; i < 3; i++) begin
            st = xs();
            dt = xs();
            wr(A_ST, {24'h0, st[7:0]});
            wr(A_RD, {24'h0, dt[7:0]});
            pps_host_model_inst.host_read(1'b1, q);
            chk("rd_stat", {24'h0, q}, {24'h0, st[7:0]});
            pps_host_model_inst.host_read(1'b0, q);
            chk("rd_data", {24'h0, q}, {24'h0, dt[7:0]});
            rdc("cfg_rd", A_CF, cfg_exp(4'h9, 1'b1, 1'b0, s));
            chk("cpu_irq_rd", {31'h0, cpu_irq}, 32'h1);
            wr(A_CF, 32'h09);
            rdc("cfg_keep", A_CF, cfg_exp(4'h9, 1'b1, 1'b0, s));
            wr(A_CF, 32'h89);
            rdc("cfg_rclr", A_CF, cfg_exp(4'h9, 1'b0, 1'b0, s));
        end
        for (int i = 0; i < 4; i++) begin
            wr(A_ST, {24'h0, i[1], 7'h0});
            wr(A_PA, {28'h0, i[0], 3'h0});
            repeat (2) @(posedge mclk);
            chk("irq_n", {31'h0, host_irq_n}, {31'h0, i[1] | i[0]});
        end
        wr(A_CF, 32'hC1);
        wr(A_EM, 32'h0);
        wr(A_ES, 32'h7);
        pps_host_model_inst.host_write(1'b0, 8'h3C);
        rdc("evt_set", A_ES, 32'h2);
        chk("irq_masked", {31'h0, cpu_irq}, 32'h0);
        wr(A_EM, 32'h2);
        repeat (2) @(posedge mclk);
        chk("irq_unmask", {31'h0, cpu_irq}, 32'h1);
        wr(A_ES, 32'h2);
        rdc("evt_clr", A_ES, 32'h0);
        chk("irq_evclr", {31'h0, cpu_irq}, 32'h0);
        complete_run();
    end
    initial begin : watchdog
        #(20 * 20000);
        err_count++;
        complete_run();
    end
endmodule : passive_parallel_slave_port_tb
